// ### logic/rac_pkg.sv
/*
  rac_pkg: constants and types shared by the register attribute cell bank.
  assumes: included before any module of the bank; nothing is imported.
*/
package rac_pkg;
  // data width of one register word
  localparam int unsigned DATA_W = 32;
  // byte lanes per word
  localparam int unsigned LANES = 4;
  // bank word indices
  localparam logic [2:0] IDX_RO = 3'h0; // read-only status word
  localparam logic [2:0] IDX_WO = 3'h1; // write-only trigger word
  localparam logic [2:0] IDX_RW = 3'h2; // plain read/write word
  localparam logic [2:0] IDX_W1C = 3'h3; // write-one-clear word
  localparam logic [2:0] IDX_W1S = 3'h4; // write-one-set word
  localparam logic [2:0] IDX_LCK = 3'h5; // lockable read/write word
  localparam logic [2:0] IDX_ONCE = 3'h6; // write-once word
  localparam logic [2:0] IDX_RSV = 3'h7; // reserved word
  // reset values
  localparam logic [31:0] RW_RST = 32'h0000_0000;
  localparam logic [31:0] LCK_RST = 32'h0000_0000;
  localparam logic [31:0] ONCE_RST = 32'h0000_0000;
  localparam logic [31:0] W1C_RST = 32'h0000_0000;
  localparam logic [31:0] W1S_RST = 32'h0000_0000;
  // arbitrary value seen on reads of the reserved word
  localparam logic [31:0] RSV_VAL = 32'h5A5A_0000;
  // cell attribute kinds
  typedef enum logic [2:0] {
    RAC_RO = 3'b000,
    RAC_RW = 3'b001,
    RAC_W1C = 3'b010,
    RAC_W1S = 3'b011,
    RAC_LCK = 3'b100,
    RAC_ONCE = 3'b101
  } rac_attr_t;
endpackage

// ### logic/rac_cell_word.sv
/*
  rac_cell_word: one 32-bit register word of a chosen access attribute.
  assumes: byte write enables already decoded; both resets asynchronous.
*/
`timescale 1ns/10ps
module rac_cell_word #(
  parameter rac_pkg::rac_attr_t ATTR = rac_pkg::RAC_RW,
  parameter bit STICKY = 1'b0,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic hard_reset_n_in,
  input wire logic power_good_n_in,
  input wire logic [3:0] wr_be_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [31:0] hw_set_in,
  input wire logic [31:0] hw_clr_in,
  input wire logic lock_in,
  input wire logic load_in,
  input wire logic [31:0] load_val_in,
  output logic [31:0] value_out
);
  // byte enables widened to a bit mask
  logic [31:0] bit_we;
  // per-bit lock for write-once
  logic [31:0] done_q;
  logic [31:0] val_d;
  logic [31:0] done_d;
  // sticky words answer only to power-good; others to either reset
  wire rst_n = STICKY ? power_good_n_in
                      : (power_good_n_in & hard_reset_n_in);
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign bit_we[g*8 +: 8] = {8{wr_be_in[g]}};
    end
  endgenerate
  // next value by attribute
  always_comb
  begin
    val_d = value_out;
    done_d = done_q;
    unique case (ATTR)
      rac_pkg::RAC_RO:
      begin
        val_d = (value_out | hw_set_in) & ~hw_clr_in;
      end
      rac_pkg::RAC_RW:
      begin
        val_d = (value_out & ~bit_we) | (wr_data_in & bit_we);
      end
      rac_pkg::RAC_W1C:
      begin
        // set wins over a clear in the same cycle
        val_d = (value_out & ~(wr_data_in & bit_we)) | hw_set_in;
      end
      rac_pkg::RAC_W1S:
      begin
        // software set wins over hardware clear
        val_d = (value_out & ~hw_clr_in) | (wr_data_in & bit_we);
      end
      rac_pkg::RAC_LCK:
      begin
        if (!lock_in)
        begin
          val_d = (value_out & ~bit_we) | (wr_data_in & bit_we);
        end
      end
      rac_pkg::RAC_ONCE:
      begin
        // only unwritten bits take data, then they lock
        val_d = (value_out & ~(bit_we & ~done_q))
              | (wr_data_in & bit_we & ~done_q);
        done_d = done_q | bit_we;
      end
      default:
      begin
        val_d = value_out;
      end
    endcase
  end
  // storage; the strap load happens on the third enabled edge after release
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value_out <= RST_VAL;
      done_q <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      if (load_in)
      begin
        value_out <= load_val_in;
      end
      else
      begin
        value_out <= val_d;
        done_q <= done_d;
      end
    end
  end
endmodule

// ### logic/rac_bank.sv
/*
  rac_bank: a bank of eight register words, one per access attribute,
  with byte-lane access, a write-only trigger word and a sticky error log.
  word map by index:
    0 read-only status, mirrors the status pins
    1 write-only trigger, reads as zero
    2 read/write command word, loaded from the straps after reset
    3 write-one-clear error log, the only sticky word
    4 write-one-set word, cleared by hardware
    5 lockable read/write word
    6 write-once word, one lock per byte lane
    7 reserved, reads a fixed pattern, writes dropped
  read data and valid are registered and answer one edge after the strobe;
  the mirror outputs follow their words one edge late.
  the write-only word keeps nothing; its write leaves as a one-edge pulse
  on trig_pulse_out, masked by the byte enables.
  assumes: the access port is on clk_in; straps and resets are pins.
  assumes: straps hold steady from before reset release until the load.
  assumes: software waits a few edges after reset before its first access,
  otherwise a write to the command word may be lost to the strap load.
*/
`timescale 1ns/10ps
module rac_bank (
  // clock, resets and freeze
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic power_good_n_in,
  input wire logic ce_in,
  // access port, same clock as the bank
  input wire logic acc_wr_in,
  input wire logic acc_rd_in,
  input wire logic [2:0] acc_idx_in,
  input wire logic [3:0] acc_be_in,
  input wire logic [31:0] acc_wdata_in,
  // hardware pins, asynchronous to clk_in
  input wire logic [31:0] hw_status_in,
  input wire logic [31:0] hw_err_set_in,
  input wire logic [31:0] hw_w1s_clr_in,
  input wire logic hw_lock_in,
  // straps are sampled into the command word once after reset
  input wire logic [31:0] strap_in,
  // read answer, registered
  output logic [31:0] acc_rdata_out,
  output logic acc_rvalid_out,
  // trigger pulse and word mirrors for the hardware side
  output logic [31:0] trig_pulse_out,
  output logic [31:0] cmd_out,
  output logic [31:0] lock_word_out,
  output logic [31:0] once_word_out,
  output logic [31:0] set_word_out
);
  // pin inputs after the two-stage synchronisers
  // _m_q is the first stage, _s_q the stage the logic reads; the lock keeps both stages in lock_m_q
  logic [31:0] stat_m_q;
  logic [31:0] stat_s_q;
  logic [31:0] err_m_q;
  logic [31:0] err_s_q;
  logic [31:0] clr_m_q;
  logic [31:0] clr_s_q;
  logic [1:0] lock_m_q;
  logic [31:0] strap_m_q;
  logic [31:0] strap_s_q;
  // strap load fires once, a few edges after release
  // counts enabled edges since release, then rests at three
  logic [1:0] boot_q;
  // word values from the cells
  // the read mux, the mirrors and the lock (bit 0 of rw_val) are the only readers
  logic [31:0] ro_val;
  logic [31:0] rw_val;
  logic [31:0] w1c_val;
  logic [31:0] w1s_val;
  logic [31:0] lck_val;
  logic [31:0] once_val;
  // non-sticky reset: either source
  // bank outputs and the boot counter use this reset;
  // the sticky error log picks its own reset inside its cell
  wire hard_rst_n = reset_n_in & power_good_n_in;

  // a write outside the word or a read leaves every lane idle
  // one-hot decode, used for every word strobe
  function automatic logic [3:0] be_of(input logic [2:0] idx,
                                       input logic [2:0] sel,
                                       input logic wr,
                                       input logic [3:0] be);
    // only the addressed word sees its lanes
    be_of = (wr && idx == sel) ? be : 4'h0;
  endfunction

  wire [3:0] be_ro = be_of(acc_idx_in, rac_pkg::IDX_RO, acc_wr_in,
                           acc_be_in);
  wire [3:0] be_wo = be_of(acc_idx_in, rac_pkg::IDX_WO, acc_wr_in,
                           acc_be_in);
  wire [3:0] be_rw = be_of(acc_idx_in, rac_pkg::IDX_RW, acc_wr_in,
                           acc_be_in);
  wire [3:0] be_w1c = be_of(acc_idx_in, rac_pkg::IDX_W1C, acc_wr_in,
                            acc_be_in);
  wire [3:0] be_w1s = be_of(acc_idx_in, rac_pkg::IDX_W1S, acc_wr_in,
                            acc_be_in);
  wire [3:0] be_lck = be_of(acc_idx_in, rac_pkg::IDX_LCK, acc_wr_in,
                            acc_be_in);
  wire [3:0] be_once = be_of(acc_idx_in, rac_pkg::IDX_ONCE, acc_wr_in,
                             acc_be_in);
  // the reserved word has no strobe, so its writes go nowhere
  // the trigger carries only the lanes that were written
  // lane k of the data bus carries byte k, low address least significant
  wire [31:0] be_mask_wo = {{8{be_wo[3]}}, {8{be_wo[2]}},
                            {8{be_wo[1]}}, {8{be_wo[0]}}};
  // lock from hardware pin or bit 0 of the command word
  // the command bit acts on the next write, the pin two edges late
  wire lock_now = lock_m_q[1] | rw_val[0];
  // strap synchronisers restart from zero after power-good, so the
  // synchronised straps first stand after the second enabled edge;
  // loading on the third edge keeps a zero from landing in the word
  wire boot_load = (boot_q == 2'b10);

  // read mux; write-only reads zero, reserved reads a fixed pattern
  // selected combinationally, captured only on a read strobe
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (acc_idx_in)
      // every index decodes, so no default is needed
      rac_pkg::IDX_RO: rd_mux = ro_val;
      // write-only data is never kept, so nothing to return
      rac_pkg::IDX_WO: rd_mux = 32'h0000_0000;
      rac_pkg::IDX_RW: rd_mux = rw_val;
      rac_pkg::IDX_W1C: rd_mux = w1c_val;
      rac_pkg::IDX_W1S: rd_mux = w1s_val;
      rac_pkg::IDX_LCK: rd_mux = lck_val;
      rac_pkg::IDX_ONCE: rd_mux = once_val;
      // reserved reads need not be zero
      rac_pkg::IDX_RSV: rd_mux = rac_pkg::RSV_VAL;
    endcase
  end

  // synchronisers; writes to the reserved word are simply dropped
  // two flops per pin before any logic looks at it; only power-good
  // clears them, so a hard reset does not lose a pending error set
  // limitation: a pin pulse shorter than a clock may be missed
  always_ff @(posedge clk_in or negedge power_good_n_in)
  begin
    if (!power_good_n_in)
    begin
      // all pins read as idle while power is not good
      stat_m_q <= 32'h0000_0000;
      stat_s_q <= 32'h0000_0000;
      err_m_q <= 32'h0000_0000;
      err_s_q <= 32'h0000_0000;
      clr_m_q <= 32'h0000_0000;
      clr_s_q <= 32'h0000_0000;
      // the lock starts open
      lock_m_q <= 2'h0;
      strap_m_q <= 32'h0000_0000;
      strap_s_q <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      // first stage samples the pin, second stage feeds the logic
      stat_m_q <= hw_status_in;
      stat_s_q <= stat_m_q;
      err_m_q <= hw_err_set_in;
      err_s_q <= err_m_q;
      clr_m_q <= hw_w1s_clr_in;
      clr_s_q <= clr_m_q;
      lock_m_q <= {lock_m_q[0], hw_lock_in};
      strap_m_q <= strap_in;
      strap_s_q <= strap_m_q;
    end
  end

  // boot counter: load straps once synchronised, then not again until a reset
  // it stops at three, so the load cannot repeat until the next reset
  // it runs from either reset, so a hard reset reloads the straps too
  always_ff @(posedge clk_in or negedge hard_rst_n)
  begin
    if (!hard_rst_n)
    begin
      boot_q <= 2'h0;
    end
    else if (ce_in && boot_q != 2'h3)
    begin
      // frozen with the rest while ce_in is low
      boot_q <= boot_q + 2'h1;
    end
  end

  // access answer and trigger pulse, registered outputs
  // every output of the bank leaves from a flop here, so the mirrors
  // trail their words by one edge; the trade buys clean output timing
  always_ff @(posedge clk_in or negedge hard_rst_n)
  begin
    if (!hard_rst_n)
    begin
      // all outputs read as zero during either reset
      acc_rdata_out <= 32'h0000_0000;
      acc_rvalid_out <= 1'b0;
      trig_pulse_out <= 32'h0000_0000;
      cmd_out <= 32'h0000_0000;
      lock_word_out <= 32'h0000_0000;
      once_word_out <= 32'h0000_0000;
      set_word_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      // valid answers each read strobe exactly once
      acc_rvalid_out <= acc_rd_in;
      // read data holds until the next read
      if (acc_rd_in)
      begin
        acc_rdata_out <= rd_mux;
      end
      // pulse lasts one cycle and nothing is stored
      trig_pulse_out <= acc_wdata_in & be_mask_wo;
      // mirrors for the hardware side
      cmd_out <= rw_val;
      lock_word_out <= lck_val;
      once_word_out <= once_val;
      set_word_out <= w1s_val;
    end
  end

  // one cell per word but the trigger and reserved words; each cell owns its own reset choice, so only
  // the error log survives a hard reset
  // unused hardware inputs are tied off to zero, and the write strobes
  // come from the shared decode above
  // the read-only cell sets from the status and clears from its inverse,
  // so it simply follows the synchronised pins
  // read-only status word follows the pin, writes ignored
  // a write to this word reaches the cell but changes nothing
  rac_cell_word #(.ATTR(rac_pkg::RAC_RO), .STICKY(1'b0),
    .RST_VAL(32'h0000_0000)) u_ro (
    .clk_in(clk_in), .ce_in(ce_in), .hard_reset_n_in(reset_n_in),
    .power_good_n_in(power_good_n_in), .wr_be_in(be_ro),
    .wr_data_in(acc_wdata_in), .hw_set_in(stat_s_q),
    .hw_clr_in(~stat_s_q), .lock_in(1'b0), .load_in(1'b0),
    .load_val_in(32'h0000_0000), .value_out(ro_val));
  // command word: strap default, never sticky
  // bit 0 doubles as the software lock of the lockable word
  rac_cell_word #(.ATTR(rac_pkg::RAC_RW), .STICKY(1'b0),
    .RST_VAL(rac_pkg::RW_RST)) u_rw (
    .clk_in(clk_in), .ce_in(ce_in), .hard_reset_n_in(reset_n_in),
    .power_good_n_in(power_good_n_in), .wr_be_in(be_rw),
    .wr_data_in(acc_wdata_in), .hw_set_in(32'h0000_0000),
    .hw_clr_in(32'h0000_0000), .lock_in(1'b0),
    .load_in(boot_load), .load_val_in(strap_s_q),
    .value_out(rw_val));
  // sticky error log, cleared by writing ones
  // a hardware set wins over a software clear in the same edge
  rac_cell_word #(.ATTR(rac_pkg::RAC_W1C), .STICKY(1'b1),
    .RST_VAL(rac_pkg::W1C_RST)) u_w1c (
    .clk_in(clk_in), .ce_in(ce_in), .hard_reset_n_in(reset_n_in),
    .power_good_n_in(power_good_n_in), .wr_be_in(be_w1c),
    .wr_data_in(acc_wdata_in), .hw_set_in(err_s_q),
    .hw_clr_in(32'h0000_0000), .lock_in(1'b0), .load_in(1'b0),
    .load_val_in(32'h0000_0000), .value_out(w1c_val));
  // software sets, hardware clears
  // a software set wins over a hardware clear in the same edge
  rac_cell_word #(.ATTR(rac_pkg::RAC_W1S), .STICKY(1'b0),
    .RST_VAL(rac_pkg::W1S_RST)) u_w1s (
    .clk_in(clk_in), .ce_in(ce_in), .hard_reset_n_in(reset_n_in),
    .power_good_n_in(power_good_n_in), .wr_be_in(be_w1s),
    .wr_data_in(acc_wdata_in), .hw_set_in(32'h0000_0000),
    .hw_clr_in(clr_s_q), .lock_in(1'b0), .load_in(1'b0),
    .load_val_in(32'h0000_0000), .value_out(w1s_val));
  // lockable word
  // locked by the pin or by command bit 0, readable throughout
  rac_cell_word #(.ATTR(rac_pkg::RAC_LCK), .STICKY(1'b0),
    .RST_VAL(rac_pkg::LCK_RST)) u_lck (
    .clk_in(clk_in), .ce_in(ce_in), .hard_reset_n_in(reset_n_in),
    .power_good_n_in(power_good_n_in), .wr_be_in(be_lck),
    .wr_data_in(acc_wdata_in), .hw_set_in(32'h0000_0000),
    .hw_clr_in(32'h0000_0000), .lock_in(lock_now), .load_in(1'b0),
    .load_val_in(32'h0000_0000), .value_out(lck_val));
  // write-once word, per byte lane
  // each lane locks on its first write until a reset
  rac_cell_word #(.ATTR(rac_pkg::RAC_ONCE), .STICKY(1'b0),
    .RST_VAL(rac_pkg::ONCE_RST)) u_once (
    .clk_in(clk_in), .ce_in(ce_in), .hard_reset_n_in(reset_n_in),
    .power_good_n_in(power_good_n_in), .wr_be_in(be_once),
    .wr_data_in(acc_wdata_in), .hw_set_in(32'h0000_0000),
    .hw_clr_in(32'h0000_0000), .lock_in(1'b0), .load_in(1'b0),
    .load_val_in(32'h0000_0000), .value_out(once_val));
endmodule

// ### bench/rac_bank_assertions.sv
/*
  rac_chk: port-level checks of the attribute bank.
  assumes: bound to rac_bank; both resets active low, ce_in mostly high.
*/
`timescale 1ns/10ps
module rac_chk (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic power_good_n_in,
  input wire logic ce_in,
  input wire logic acc_wr_in,
  input wire logic acc_rd_in,
  input wire logic [2:0] acc_idx_in,
  input wire logic [3:0] acc_be_in,
  input wire logic [31:0] acc_wdata_in,
  input wire logic [31:0] acc_rdata_out,
  input wire logic acc_rvalid_out,
  input wire logic [31:0] trig_pulse_out,
  input wire logic [31:0] cmd_out,
  input wire logic [31:0] lock_word_out,
  input wire logic [31:0] set_word_out
);
  // byte lanes spread to bit mask, lane 0 lowest
  wire [31:0] lane_m = {{8{acc_be_in[3]}}, {8{acc_be_in[2]}},
    {8{acc_be_in[1]}}, {8{acc_be_in[0]}}};
  wire [31:0] masked = acc_wdata_in & lane_m;
  wire hit_wr = ce_in && acc_wr_in;
  wire hit_rd = ce_in && acc_rd_in;
  wire rw_wr = hit_wr && acc_idx_in == rac_pkg::IDX_RW;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in || !power_good_n_in);
  rd_valid_a: assert property (hit_rd |=> acc_rvalid_out)
    else $error("read without valid");
  rd_quiet_a: assert property (ce_in && !hit_rd |=> !acc_rvalid_out)
    else $error("valid without read");
  wo_zero_a: assert property (hit_rd && acc_idx_in == rac_pkg::IDX_WO
    |=> acc_rdata_out == 32'h0) else $error("write-only read not zero");
  rsv_read_a: assert property (hit_rd && acc_idx_in == rac_pkg::IDX_RSV
    |=> acc_rdata_out == rac_pkg::RSV_VAL) else $error("reserved read");
  trig_pulse_a: assert property (hit_wr && acc_idx_in == rac_pkg::IDX_WO
    |=> trig_pulse_out == $past(masked)) else $error("trigger value");
  trig_idle_a: assert property (!(hit_wr &&
    acc_idx_in == rac_pkg::IDX_WO) |=> trig_pulse_out == 32'h0)
    else $error("trigger not one cycle");
  rw_store_a: assert property (rw_wr && acc_be_in == 4'hF
    |=> ##1 cmd_out == $past(acc_wdata_in, 2)) else $error("rw store");
  w1s_set_a: assert property (hit_wr && acc_idx_in == rac_pkg::IDX_W1S
    |=> ##1 (set_word_out & $past(masked, 2)) == $past(masked, 2))
    else $error("set bits missing");
  // cmd_out lags the word; a write one edge earlier would blur the lock
  lck_hold_a: assert property (hit_wr && acc_idx_in == rac_pkg::IDX_LCK
    && cmd_out[0] && !$past(rw_wr) |=> ##1 $stable(lock_word_out))
    else $error("locked word changed");
  cover property (hit_wr && acc_idx_in == rac_pkg::IDX_WO);
  cover property (hit_rd && acc_idx_in == rac_pkg::IDX_RSV);
  cover property (hit_wr && acc_idx_in == rac_pkg::IDX_LCK && cmd_out[0]);
endmodule
bind rac_bank rac_chk chk_u (.*);

// ### bench/testbench.sv
/*
  testbench: directed checks of the attribute bank at its ports.
  assumes: rac_pkg, rac_bank and the bound checker compiled first.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, g); fail_count++; end end
module testbench;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic power_good_n_in = 1'b0;
  logic ce_in = 1'b1; // held high except in the freeze scenario
  logic acc_wr_in = 1'b0;
  logic acc_rd_in = 1'b0;
  logic [2:0] acc_idx_in = 3'h0;
  logic [3:0] acc_be_in = 4'h0;
  logic [31:0] acc_wdata_in = 32'h0;
  logic [31:0] hw_status_in = 32'h0;
  logic [31:0] hw_err_set_in = 32'h0;
  logic [31:0] hw_w1s_clr_in = 32'h0;
  logic hw_lock_in = 1'b0;
  logic [31:0] strap_in = 32'hC0DE_0102; // bit 0 low: no lock at boot
  logic [31:0] acc_rdata_out, trig_pulse_out, cmd_out;
  logic [31:0] lock_word_out, once_word_out, set_word_out;
  logic acc_rvalid_out;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  rac_bank dut_u (.*);
  initial forever #10 clk_in = ~clk_in;
  // hang guard, run needs well under 1000 cycles
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // reset held 8 cycles; first access taken 5 edges after release
  task automatic rst(input bit pg);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    if (pg)
      power_good_n_in <= 1'b0;
    tick(8);
    `CHK("cmd_rst", 32'h0, cmd_out)
    reset_n_in <= 1'b1;
    power_good_n_in <= 1'b1;
    tick(3);
  endtask
  // one write, taken at the second edge
  task automatic wr(input logic [2:0] i, input logic [3:0] b,
    input logic [31:0] d);
    @(posedge clk_in);
    acc_wr_in <= 1'b1;
    acc_idx_in <= i;
    acc_be_in <= b;
    acc_wdata_in <= d;
    @(posedge clk_in);
    acc_wr_in <= 1'b0;
  endtask
  // one read, result judged after its answering edge
  task automatic rdc(input logic [2:0] i, input logic [31:0] e);
    @(posedge clk_in);
    acc_rd_in <= 1'b1;
    acc_idx_in <= i;
    @(posedge clk_in);
    acc_rd_in <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, acc_rvalid_out)
    `CHK("rdata", e, acc_rdata_out)
    // end on an edge so the next stimulus lands on one too
    @(posedge clk_in);
  endtask
  task automatic t_boot();
    // defaults are read back before anything is programmed
    rdc(rac_pkg::IDX_RW, strap_in);
    rdc(rac_pkg::IDX_W1S, rac_pkg::W1S_RST);
  endtask
  task automatic t_rw();
    wr(rac_pkg::IDX_RW, 4'hF, 32'h1122_3344);
    // lanes outside the enables keep their bytes, no merge needed
    wr(rac_pkg::IDX_RW, 4'h2, 32'hFFFF_ABFF);
    rdc(rac_pkg::IDX_RW, 32'h1122_AB44);
    `CHK("cmd", 32'h1122_AB44, cmd_out)
  endtask
  // clock enable low: the write is not taken and the word holds
  task automatic t_ce();
    ce_in <= 1'b0;
    wr(rac_pkg::IDX_RW, 4'hF, 32'h0000_0000);
    ce_in <= 1'b1;
    rdc(rac_pkg::IDX_RW, 32'h1122_AB44);
    `CHK("cmd_frz", 32'h1122_AB44, cmd_out)
  endtask
  task automatic t_ro();
    hw_status_in <= 32'hA5A5_0F0F;
    tick(4);
    wr(rac_pkg::IDX_RO, 4'hF, 32'h0);
    rdc(rac_pkg::IDX_RO, 32'hA5A5_0F0F);
  endtask
  task automatic t_wo();
    wr(rac_pkg::IDX_WO, 4'h3, 32'hDEAD_BEEF);
    #1;
    `CHK("trig", 32'h0000_BEEF, trig_pulse_out)
    tick(1);
    #1;
    `CHK("trig_end", 32'h0, trig_pulse_out)
    rdc(rac_pkg::IDX_WO, 32'h0);
    // the reserved word is read, never written
    // a driver would mask this pattern; here it checks the device
    rdc(rac_pkg::IDX_RSV, rac_pkg::RSV_VAL);
  endtask
  task automatic t_w1s();
    wr(rac_pkg::IDX_W1S, 4'hF, 32'h0000_00F0);
    wr(rac_pkg::IDX_W1S, 4'hF, 32'h0);
    rdc(rac_pkg::IDX_W1S, 32'h0000_00F0);
    hw_w1s_clr_in <= 32'h0000_0030;
    tick(4);
    hw_w1s_clr_in <= 32'h0;
    rdc(rac_pkg::IDX_W1S, 32'h0000_00C0);
    `CHK("set", 32'h0000_00C0, set_word_out)
  endtask
  // lock by pin, then by command bit 0, then released
  task automatic t_lck();
    wr(rac_pkg::IDX_LCK, 4'hF, 32'h0000_1234);
    hw_lock_in <= 1'b1;
    tick(4);
    wr(rac_pkg::IDX_LCK, 4'hF, 32'h0000_5678);
    rdc(rac_pkg::IDX_LCK, 32'h0000_1234);
    hw_lock_in <= 1'b0;
    tick(4);
    wr(rac_pkg::IDX_RW, 4'h1, 32'h0000_0001);
    wr(rac_pkg::IDX_LCK, 4'hF, 32'h0000_9999);
    rdc(rac_pkg::IDX_LCK, 32'h0000_1234);
    `CHK("lock", 32'h0000_1234, lock_word_out)
    wr(rac_pkg::IDX_RW, 4'h1, 32'h0);
    wr(rac_pkg::IDX_LCK, 4'hF, 32'h0000_9999);
    rdc(rac_pkg::IDX_LCK, 32'h0000_9999);
  endtask
  task automatic t_once();
    wr(rac_pkg::IDX_ONCE, 4'h1, 32'h0000_0011);
    wr(rac_pkg::IDX_ONCE, 4'h3, 32'h0000_2222);
    rdc(rac_pkg::IDX_ONCE, 32'h0000_2211);
    `CHK("once", 32'h0000_2211, once_word_out)
    rst(1'b0);
    wr(rac_pkg::IDX_ONCE, 4'h1, 32'h0000_0033);
    rdc(rac_pkg::IDX_ONCE, 32'h0000_0033);
  endtask
  // error log survives hard reset only
  task automatic t_w1c();
    hw_err_set_in <= 32'h0000_0011;
    tick(4);
    hw_err_set_in <= 32'h0;
    tick(4);
    wr(rac_pkg::IDX_W1C, 4'hF, 32'h0);
    rdc(rac_pkg::IDX_W1C, 32'h0000_0011);
    wr(rac_pkg::IDX_W1C, 4'hF, 32'h0000_0001);
    rdc(rac_pkg::IDX_W1C, 32'h0000_0010);
    wr(rac_pkg::IDX_RW, 4'hF, 32'h0000_7770);
    rst(1'b0);
    rdc(rac_pkg::IDX_W1C, 32'h0000_0010);
    rdc(rac_pkg::IDX_RW, strap_in);
    rst(1'b1);
    rdc(rac_pkg::IDX_W1C, 32'h0);
  endtask
  initial
  begin
    rst(1'b1);
    t_boot();
    t_rw();
    t_ce();
    t_ro();
    t_wo();
    t_w1s();
    t_lck();
    t_once();
    t_w1c();
    complete_run();
  end
endmodule
